// file: rtl/scd_pkg.sv
// shared types and constants for the opcode decoder and its timing table
// assumes one 50 MHz clock and opcodes arriving one byte at a time
package scd_pkg;

	// clock rate, kept for reference by timing math
	localparam int CLK_MHZ = 50;

	// widths
	localparam int OP_W = 8;
	localparam int CNT_W = 3;
	localparam int IDX_W = 3;

	// instruction lengths in bytes
	localparam logic [1:0] LEN_1 = 2'h1;
	localparam logic [1:0] LEN_2 = 2'h2;
	localparam logic [1:0] LEN_3 = 2'h3;

	// execution times in clock cycles
	localparam logic [2:0] CYC_1 = 3'h1;
	localparam logic [2:0] CYC_2 = 3'h2;
	localparam logic [2:0] CYC_3 = 3'h3;
	localparam logic [2:0] CYC_4 = 3'h4;
	localparam logic [2:0] CYC_5 = 3'h5;
	localparam logic [2:0] CYC_6 = 3'h6;

	// counter value on the last busy cycle
	localparam logic [2:0] CNT_LAST = 3'h1;

	// reset values
	localparam logic RDY_RST = 1'b1;
	localparam logic [2:0] CNT_RST = 3'h0;

	// opcodes that work on the active data pointer
	localparam logic [7:0] OPC_INC_DP = 8'hA3;
	localparam logic [7:0] OPC_LD_DP = 8'h90;
	localparam logic [7:0] OPC_MOVC_DP = 8'h93;
	localparam logic [7:0] OPC_RDX_DP = 8'hE0;
	localparam logic [7:0] OPC_WRX_DP = 8'hF0;
	localparam logic [7:0] OPC_JMP_DP = 8'h73;

	// opcode field patterns for operand forms
	localparam logic [2:0] IND_LOW = 3'h3;
	localparam logic [2:0] MOVX_HI = 3'h7;
	localparam logic [2:0] MOVX_LOW = 3'h1;

	typedef enum logic [2:0] {
		CLS_NOP = 3'b000,
		CLS_ARITH = 3'b001,
		CLS_LOGIC = 3'b010,
		CLS_XFER = 3'b011,
		CLS_BRANCH = 3'b100,
		CLS_BOOL = 3'b101,
		CLS_MULDIV = 3'b110,
		CLS_RSVD = 3'b111
	} scd_cls_t;

	typedef enum logic [1:0] {
		FRM_NONE = 2'b00,
		FRM_REG = 2'b01,
		FRM_IND = 2'b10
	} scd_form_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_EXEC = 1'b1
	} scd_st_t;

	typedef struct packed {
		scd_cls_t cls;
		logic [1:0] len;
		logic [2:0] cyc;
	} scd_info_t;

	typedef struct packed {
		scd_cls_t cls;
		scd_form_t form;
		logic [1:0] len;
		logic [2:0] cyc;
		logic [4:0] reg_addr;
		logic active_data_pointer_use;
		logic active_data_pointer_sel;
		logic [7:0] opcode;
	} scd_dec_t;

	typedef struct packed {
		scd_st_t st;
		logic ready;
		logic busy;
		logic done;
		logic [2:0] cnt;
		scd_dec_t dec;
	} scd_state_t;

endpackage

// file: rtl/scd_optab.sv
// opcode to class, length and cycle count lookup, purely combinational
// assumes the caller registers the result
`timescale 1ns/100ps
module scd_optab (
	input wire logic [7:0] opcode,
	output scd_pkg::scd_info_t info
);

	// one entry per group of opcodes sharing class, length and time
	always_comb begin
		case (opcode) inside
			8'h00: info = {scd_pkg::CLS_NOP, scd_pkg::LEN_1, scd_pkg::CYC_1};
			// arithmetic
			[8'h28:8'h2F], [8'h38:8'h3F], [8'h98:8'h9F], 8'h04, 8'hA3, 8'h14, 8'hD4: begin
				info = {scd_pkg::CLS_ARITH, scd_pkg::LEN_1, scd_pkg::CYC_1};
			end
			8'h25, 8'h35, 8'h95, 8'h24, 8'h34, 8'h94: begin
				info = {scd_pkg::CLS_ARITH, scd_pkg::LEN_2, scd_pkg::CYC_2};
			end
			8'h26, 8'h27, 8'h36, 8'h37, 8'h96, 8'h97, [8'h08:8'h0F], [8'h18:8'h1F]: begin
				info = {scd_pkg::CLS_ARITH, scd_pkg::LEN_1, scd_pkg::CYC_2};
			end
			8'h05, 8'h15: info = {scd_pkg::CLS_ARITH, scd_pkg::LEN_2, scd_pkg::CYC_3};
			8'h06, 8'h07, 8'h16, 8'h17: info = {scd_pkg::CLS_ARITH, scd_pkg::LEN_1, scd_pkg::CYC_3};
			8'hA4, 8'h84: info = {scd_pkg::CLS_MULDIV, scd_pkg::LEN_1, scd_pkg::CYC_5};
			// logic
			[8'h48:8'h4F], [8'h58:8'h5F], [8'h68:8'h6F], 8'hE4, 8'hF4, 8'hC4: begin
				info = {scd_pkg::CLS_LOGIC, scd_pkg::LEN_1, scd_pkg::CYC_1};
			end
			8'h23, 8'h33, 8'h03, 8'h13: info = {scd_pkg::CLS_LOGIC, scd_pkg::LEN_1, scd_pkg::CYC_1};
			8'h45, 8'h55, 8'h65, 8'h44, 8'h54, 8'h64: begin
				info = {scd_pkg::CLS_LOGIC, scd_pkg::LEN_2, scd_pkg::CYC_2};
			end
			8'h46, 8'h47, 8'h56, 8'h57, 8'h66, 8'h67: begin
				info = {scd_pkg::CLS_LOGIC, scd_pkg::LEN_1, scd_pkg::CYC_2};
			end
			8'h42, 8'h52, 8'h62: info = {scd_pkg::CLS_LOGIC, scd_pkg::LEN_2, scd_pkg::CYC_3};
			8'h43, 8'h53, 8'h63: info = {scd_pkg::CLS_LOGIC, scd_pkg::LEN_3, scd_pkg::CYC_4};
			// data transfer
			[8'hE8:8'hEF]: info = {scd_pkg::CLS_XFER, scd_pkg::LEN_1, scd_pkg::CYC_1};
			8'hE5, 8'h74, [8'h78:8'h7F]: info = {scd_pkg::CLS_XFER, scd_pkg::LEN_2, scd_pkg::CYC_2};
			[8'hF8:8'hFF], [8'hC8:8'hCF], 8'hE6, 8'hE7: begin
				info = {scd_pkg::CLS_XFER, scd_pkg::LEN_1, scd_pkg::CYC_2};
			end
			[8'hA8:8'hAF], 8'h86, 8'h87, 8'hC0: begin
				info = {scd_pkg::CLS_XFER, scd_pkg::LEN_2, scd_pkg::CYC_4};
			end
			8'hF5, [8'h88:8'h8F], 8'h76, 8'h77, 8'hC5, 8'hD0: begin
				info = {scd_pkg::CLS_XFER, scd_pkg::LEN_2, scd_pkg::CYC_3};
			end
			8'h85: info = {scd_pkg::CLS_XFER, scd_pkg::LEN_3, scd_pkg::CYC_4};
			8'h75, 8'h90: info = {scd_pkg::CLS_XFER, scd_pkg::LEN_3, scd_pkg::CYC_3};
			8'hF6, 8'hF7, 8'h93, 8'h83, 8'hE2, 8'hE3, 8'hE0, 8'hC6, 8'hC7, 8'hD6, 8'hD7: begin
				info = {scd_pkg::CLS_XFER, scd_pkg::LEN_1, scd_pkg::CYC_3};
			end
			8'hA6, 8'hA7: info = {scd_pkg::CLS_XFER, scd_pkg::LEN_2, scd_pkg::CYC_5};
			8'hF2, 8'hF3, 8'hF0: info = {scd_pkg::CLS_XFER, scd_pkg::LEN_1, scd_pkg::CYC_4};
			// program branches; absolute forms carry address bits in the top three
			8'b???00001: info = {scd_pkg::CLS_BRANCH, scd_pkg::LEN_2, scd_pkg::CYC_3};
			8'b???10001: info = {scd_pkg::CLS_BRANCH, scd_pkg::LEN_2, scd_pkg::CYC_6};
			8'h12: info = {scd_pkg::CLS_BRANCH, scd_pkg::LEN_3, scd_pkg::CYC_6};
			8'h22, 8'h32: info = {scd_pkg::CLS_BRANCH, scd_pkg::LEN_1, scd_pkg::CYC_4};
			8'h02, 8'h20, 8'h30, 8'h10, [8'hB4:8'hBF], 8'hD5: begin
				info = {scd_pkg::CLS_BRANCH, scd_pkg::LEN_3, scd_pkg::CYC_4};
			end
			8'h80, 8'h60, 8'h70, 8'h40, 8'h50, [8'hD8:8'hDF]: begin
				info = {scd_pkg::CLS_BRANCH, scd_pkg::LEN_2, scd_pkg::CYC_3};
			end
			8'h73: info = {scd_pkg::CLS_BRANCH, scd_pkg::LEN_1, scd_pkg::CYC_2};
			// boolean
			8'hC3, 8'hD3, 8'hB3: info = {scd_pkg::CLS_BOOL, scd_pkg::LEN_1, scd_pkg::CYC_1};
			8'hC2, 8'hD2, 8'hB2, 8'h92: info = {scd_pkg::CLS_BOOL, scd_pkg::LEN_2, scd_pkg::CYC_3};
			8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: begin
				info = {scd_pkg::CLS_BOOL, scd_pkg::LEN_2, scd_pkg::CYC_2};
			end
			// the one unassigned code runs as a one-cycle filler
			default: info = {scd_pkg::CLS_RSVD, scd_pkg::LEN_1, scd_pkg::CYC_1};
		endcase
	end

endmodule // scd_optab

// file: rtl/scd_decoder.sv
// opcode decoder and cycle timer for the single-cycle-per-byte cpu core
// assumes opcode bytes from program memory, synchronous to mclk
//
// Behaviour
// - 0x28-0x2F add register: 1 byte, 1 cycle
// - add with carry forms and their timings
// - subtract with borrow forms and their timings
// - increment direct 3, pointer/acc 1, register 2
// - and to direct: 0x52 3, 0x53 4
// - or register 1, 0x42 3, 0x43 4
// - xor register 1, 0x62 3, 0x63 4
// - clear, complement, swap accumulator: one cycle
// - accumulator rotates: one byte, one cycle
// - direct to register 4, acc to register 2
// - load data pointer 0x90: 3 bytes, 3 cycles
// - code reads 3 cycles, 0x93 and 0x83
// - external reads 3 cycles, writes 4 cycles
// - push 4 cycles, pop 3, two bytes
// - low nibble exchange 0xD6-0xD7, 3 cycles
// - jumps 3/4 cycles, calls 6, returns 4
// - computed jump 0x73: 1 byte, 2 cycles
// - conditional relative jumps: 2 bytes, 3 cycles
// - bit test jumps: 3 bytes, 4 cycles
// - compare and jump forms: 3 bytes, 4 cycles
// - decrement and jump: register 3, direct 4
// - carry bit logic and moves, 1-3 cycles
// - two status bits pick working register bank
// - select bit picks active data pointer
`timescale 1ns/100ps
module scd_decoder (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic op_valid,
	input wire logic [7:0] op_byte,
	input wire logic bank_select_high,
	input wire logic bank_select_low,
	input wire logic pointer_select_bit,
	output logic op_ready,
	output logic busy,
	output logic done,
	output scd_pkg::scd_dec_t dec
);

	scd_pkg::scd_state_t s_r;
	scd_pkg::scd_state_t s_nxt;
	scd_pkg::scd_info_t info;
	scd_pkg::scd_form_t form;
	logic [2:0] idx;
	logic active_data_pointer_use;
	logic take;

	// class, length and time of the offered opcode
	scd_optab u_optab (
		.opcode(op_byte),
		.info(info)
	);

	// an opcode is taken only while idle
	assign take = op_valid && s_r.ready;

	// operand form and register index from opcode bits
	always_comb begin
		form = scd_pkg::FRM_NONE;
		idx = '0;
		if (op_byte[3]) begin
			form = scd_pkg::FRM_REG;
			idx = op_byte[2:0];
		end else if (op_byte[3:1] == scd_pkg::IND_LOW) begin
			form = scd_pkg::FRM_IND;
			idx = {2'b00, op_byte[0]};
		end else if (op_byte[7:5] == scd_pkg::MOVX_HI && op_byte[3:1] == scd_pkg::MOVX_LOW) begin
			// external moves through r0/r1 share the indirect form
			form = scd_pkg::FRM_IND;
			idx = {2'b00, op_byte[0]};
		end
	end

	// every pointer instruction follows the select bit
	always_comb begin
		active_data_pointer_use = 1'b0;
		if (op_byte == scd_pkg::OPC_INC_DP || op_byte == scd_pkg::OPC_LD_DP) begin
			active_data_pointer_use = 1'b1;
		end else if (op_byte == scd_pkg::OPC_MOVC_DP || op_byte == scd_pkg::OPC_JMP_DP) begin
			active_data_pointer_use = 1'b1;
		end else if (op_byte == scd_pkg::OPC_RDX_DP || op_byte == scd_pkg::OPC_WRX_DP) begin
			active_data_pointer_use = 1'b1;
		end
	end

	// next state: idle takes an opcode, exec counts its cycles down
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			scd_pkg::ST_IDLE: begin
				if (take) begin
					s_nxt.st = scd_pkg::ST_EXEC;
					s_nxt.ready = 1'b0;
					s_nxt.busy = 1'b1;
					s_nxt.cnt = info.cyc;
					s_nxt.dec.cls = info.cls;
					s_nxt.dec.len = info.len;
					s_nxt.dec.cyc = info.cyc;
					s_nxt.dec.form = form;
					s_nxt.dec.opcode = op_byte;
					// bank bits sampled with the opcode; a later change waits
					s_nxt.dec.reg_addr = {bank_select_high, bank_select_low, idx};
					s_nxt.dec.active_data_pointer_use = active_data_pointer_use;
					s_nxt.dec.active_data_pointer_sel = pointer_select_bit;
				end
			end
			scd_pkg::ST_EXEC: begin
				s_nxt.cnt = s_r.cnt - 3'h1;
				if (s_r.cnt == scd_pkg::CNT_LAST) begin
					s_nxt.st = scd_pkg::ST_IDLE;
					s_nxt.busy = 1'b0;
					s_nxt.ready = 1'b1;
					s_nxt.done = 1'b1;
				end
			end
			default: begin
				s_nxt.st = scd_pkg::ST_IDLE;
			end
		endcase
		if (!rst_b) begin
			s_nxt = '0;
			s_nxt.ready = scd_pkg::RDY_RST;
			s_nxt.cnt = scd_pkg::CNT_RST;
		end
	end

	// single state register, synchronous reset folded in above
	always_ff @(posedge mclk) begin
		s_r <= s_nxt;
	end

	// outputs straight from the state register
	assign op_ready = s_r.ready;
	assign busy = s_r.busy;
	assign done = s_r.done;
	assign dec = s_r.dec;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	// one-cycle register add
	AST_ADD_RN: assert property (
		take && op_byte inside {[8'h28:8'h2F]}
		|=> dec.cls == scd_pkg::CLS_ARITH && dec.len == scd_pkg::LEN_1 && busy ##1 done && op_ready
	) else $error("register add timing wrong");

	// direct add with carry: two bytes, two cycles
	AST_ADDC_DIR: assert property (
		take && op_byte == 8'h35 |=> dec.len == scd_pkg::LEN_2 ##0 busy [*2] ##1 done
	) else $error("direct add with carry timing wrong");

	// direct increment runs three cycles
	AST_INC_DIR: assert property (
		take && op_byte == 8'h05 |=> busy [*3] ##1 (done && !busy)
	) else $error("direct increment timing wrong");

	// and immediate to direct: three bytes, four cycles
	AST_ANL_IMM: assert property (
		take && op_byte == 8'h53 |=> dec.len == scd_pkg::LEN_3 ##0 busy [*4] ##1 done
	) else $error("and immediate to direct timing wrong");

	// long call holds busy six cycles
	AST_LCALL: assert property (
		take && op_byte == 8'h12 |=> (busy && !op_ready) [*6] ##1 (done && op_ready)
	) else $error("long call timing wrong");

	// multiply and divide run five cycles
	AST_MULDIV: assert property (
		take && (op_byte == 8'hA4 || op_byte == 8'h84)
		|=> dec.cls == scd_pkg::CLS_MULDIV ##0 busy [*5] ##1 done
	) else $error("multiply or divide timing wrong");

	// register forms land in the selected bank
	AST_BANK: assert property (
		take && op_byte[3]
		|=> dec.reg_addr == {$past(bank_select_high), $past(bank_select_low), $past(op_byte[2:0])}
	) else $error("register bank address wrong");

	// pointer increment carries the select bit
	AST_ACTIVE_DATA_POINTER: assert property (
		take && op_byte == scd_pkg::OPC_INC_DP
		|=> dec.active_data_pointer_use && dec.active_data_pointer_sel == $past(pointer_select_bit) && dec.cyc == scd_pkg::CYC_1
	) else $error("data pointer select wrong");

	// indirect forms name r0 or r1 from bit zero
	AST_IND: assert property (
		take && op_byte[3:1] == scd_pkg::IND_LOW
		|=> dec.form == scd_pkg::FRM_IND && dec.reg_addr[2:0] == {2'b00, $past(op_byte[0])}
	) else $error("indirect register index wrong");

	// nothing is taken while busy, and done stays low while busy
	AST_NO_OVERLAP: assert property (
		busy |-> !op_ready ##0 !done
	) else $error("opcode accepted while busy");

	// subtract with borrow direct, immediate and indirect forms run two cycles
	AST_SUBB_MEM: assert property (
		take && op_byte inside {8'h94, 8'h95, 8'h96, 8'h97} |=> busy [*2] ##1 done
	) else $error("subtract with borrow timing wrong");

	// register increment is a register form of two cycles
	AST_INC_REG: assert property (
		take && op_byte inside {[8'h08:8'h0F]} |=> dec.form == scd_pkg::FRM_REG ##0 busy [*2] ##1 done
	) else $error("register increment timing wrong");

	// or immediate to direct: three bytes, four cycles
	AST_ORL_IMM: assert property (
		take && op_byte == 8'h43 |=> dec.len == scd_pkg::LEN_3 ##0 busy [*4] ##1 done
	) else $error("or immediate to direct timing wrong");

	// xor accumulator to direct runs three cycles
	AST_XRL_DIR: assert property (
		take && op_byte == 8'h62 |=> busy [*3] ##1 done
	) else $error("xor to direct timing wrong");

	// clear, complement and swap finish in one cycle
	AST_ACC_ONE: assert property (
		take && op_byte inside {8'hE4, 8'hF4, 8'hC4} |=> dec.len == scd_pkg::LEN_1 && busy ##1 done
	) else $error("accumulator one cycle op timing wrong");

	// rotates are one byte, one cycle
	AST_ROTATE: assert property (
		take && op_byte inside {8'h23, 8'h33, 8'h03, 8'h13} |=> dec.len == scd_pkg::LEN_1 && busy ##1 done
	) else $error("rotate timing wrong");

	// direct to register: two bytes, four cycles
	AST_MOV_RDIR: assert property (
		take && op_byte inside {[8'hA8:8'hAF]} |=> dec.len == scd_pkg::LEN_2 ##0 busy [*4] ##1 done
	) else $error("direct to register timing wrong");

	// pointer load: three bytes, three cycles, uses the pointer
	AST_LD_DP: assert property (
		take && op_byte == scd_pkg::OPC_LD_DP |=> dec.len == scd_pkg::LEN_3 && dec.active_data_pointer_use ##0 busy [*3] ##1 done
	) else $error("pointer load timing wrong");

	// code reads run three cycles
	AST_CODE_RD: assert property (
		take && op_byte inside {8'h93, 8'h83} |=> busy [*3] ##1 done
	) else $error("code read timing wrong");

	// external writes run four cycles
	AST_EXT_WR: assert property (
		take && op_byte inside {8'hF0, 8'hF2, 8'hF3} |=> busy [*4] ##1 done
	) else $error("external write timing wrong");

	// push: two bytes, four cycles
	AST_PUSH: assert property (
		take && op_byte == 8'hC0 |=> dec.len == scd_pkg::LEN_2 ##0 busy [*4] ##1 done
	) else $error("push timing wrong");

	// low nibble exchange is indirect, three cycles
	AST_XCHD: assert property (
		take && op_byte inside {8'hD6, 8'hD7} |=> dec.form == scd_pkg::FRM_IND ##0 busy [*3] ##1 done
	) else $error("nibble exchange timing wrong");

	// returns run four cycles
	AST_RET: assert property (
		take && op_byte inside {8'h22, 8'h32} |=> dec.len == scd_pkg::LEN_1 ##0 busy [*4] ##1 done
	) else $error("return timing wrong");

	// computed jump uses the pointer, two cycles
	AST_JMP_DP: assert property (
		take && op_byte == scd_pkg::OPC_JMP_DP |=> dec.active_data_pointer_use ##0 busy [*2] ##1 done
	) else $error("computed jump timing wrong");

	// conditional relative jumps: two bytes, three cycles
	AST_COND_JMP: assert property (
		take && op_byte inside {8'h60, 8'h70, 8'h40, 8'h50} |=> dec.len == scd_pkg::LEN_2 ##0 busy [*3] ##1 done
	) else $error("conditional jump timing wrong");

	// bit test jumps: three bytes, four cycles
	AST_BIT_JMP: assert property (
		take && op_byte inside {8'h20, 8'h30, 8'h10} |=> dec.len == scd_pkg::LEN_3 ##0 busy [*4] ##1 done
	) else $error("bit test jump timing wrong");

	// compare and jump forms: three bytes, four cycles
	AST_CJNE: assert property (
		take && op_byte inside {[8'hB4:8'hBF]} |=> dec.len == scd_pkg::LEN_3 ##0 busy [*4] ##1 done
	) else $error("compare and jump timing wrong");

	// register decrement and jump runs three cycles
	AST_DJNZ_REG: assert property (
		take && op_byte inside {[8'hD8:8'hDF]} |=> busy [*3] ##1 done
	) else $error("decrement and jump timing wrong");

	// carry into a bit takes three cycles
	AST_BIT_MOV: assert property (
		take && op_byte == 8'h92 |=> busy [*3] ##1 done
	) else $error("carry to bit timing wrong");

	// bit into carry takes two cycles
	AST_BIT_CARRY: assert property (
		take && op_byte == 8'hA2 |=> dec.len == scd_pkg::LEN_2 ##0 busy [*2] ##1 done
	) else $error("bit to carry timing wrong");

	// main scenarios
	COV_ONE_CYCLE: cover property (take && op_byte == 8'hE4 ##1 busy ##1 done);
	COV_CALL: cover property (take && op_byte == 8'h12 ##1 busy [*6] ##1 done);
	COV_BACK_TO_BACK: cover property (done && take ##1 busy);
	COV_BANK3: cover property (take && op_byte[3] && bank_select_high && bank_select_low);

endmodule // scd_decoder

// file: sim/scd_pmem.sv
// program memory model that offers opcode bytes to the decoder
// assumes the bench loads mem and moves pc and fetch off the rising edge
`timescale 1ns/100ps
module scd_pmem (
	input wire logic mclk,
	input wire logic [6:0] pc,
	input wire logic fetch,
	output logic op_valid,
	output logic [7:0] op_byte
);
	logic [7:0] mem [0:127];
	logic [7:0] last_r = 8'h00;

	// remember the last byte put out
	always_ff @(posedge mclk) begin
		if (fetch)
			last_r <= mem[pc];
	end

	// released bus shows the inverse, so a stale byte never passes for valid data
	assign op_valid = fetch;
	assign op_byte = fetch ? mem[pc] : ~last_r;
endmodule // scd_pmem

// file: sim/single_cycle_cpu_opcode_timing_bench.sv
// self-checking bench for the opcode decoder and cycle timer
// assumes scd_decoder and the program memory model scd_pmem
`timescale 1ns/100ps
module single_cycle_cpu_opcode_timing_bench;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic [6:0] pc = 7'h00;
	logic fetch = 1'b0;
	logic bank_select_high = 1'b0;
	logic bank_select_low = 1'b0;
	logic pointer_select_bit = 1'b0;
	logic op_valid, op_ready, busy, done;
	logic [7:0] op_byte;
	scd_pkg::scd_dec_t dec;
	int n_errors = 0;
	int n_checks = 0;
	// opcode, bytes, cycles
	logic [15:0] tab [0:67] = '{16'h2B11, 16'hD713, 16'h9033, 16'hA511, 16'h1236,
		16'h3A11, 16'h3522, 16'h3612, 16'h3422,
		16'h9F11, 16'h9522, 16'h9712, 16'h9422,
		16'h0523, 16'hA311, 16'h0411, 16'h0C12,
		16'h5223, 16'h5334, 16'h5811,
		16'h4811, 16'h4223, 16'h4334,
		16'h6F11, 16'h6223, 16'h6334,
		16'hE411, 16'hF411, 16'hC411,
		16'h2311, 16'h3311, 16'h0311, 16'h1311,
		16'hA824, 16'hF812,
		16'h9313, 16'h8313,
		16'hE013, 16'hE213, 16'hF014, 16'hF214,
		16'hC024, 16'hD023,
		16'h8023, 16'h0234, 16'h2214, 16'h3214,
		16'h7312,
		16'h6023, 16'h7023, 16'h4023, 16'h5023,
		16'h2034, 16'h3034, 16'h1034,
		16'hB534, 16'hB434, 16'hB834, 16'hB634,
		16'hD823, 16'hD534,
		16'hB022, 16'hA022, 16'hA222, 16'h9223,
		16'hA415, 16'h8415, 16'h1126};

	scd_pmem u_scd_pmem (.mclk(mclk), .pc(pc), .fetch(fetch), .op_valid(op_valid), .op_byte(op_byte));

	scd_decoder u_scd_decoder (.mclk(mclk), .rst_b(rst_b), .op_valid(op_valid), .op_byte(op_byte),
		.bank_select_high(bank_select_high), .bank_select_low(bank_select_low),
		.pointer_select_bit(pointer_select_bit), .op_ready(op_ready), .busy(busy), .done(done), .dec(dec));

	// 50 MHz clock
	initial begin
		forever #10 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one instruction; nag >= 0 offers that entry while busy, then back to back
	task automatic run_op(input int i, input logic [2:0] sel, input int nag);
		int n;
		logic [15:0] e;
		e = tab[i];
		pc = 7'(i);
		fetch = 1'b1;
		{bank_select_high, bank_select_low, pointer_select_bit} = sel;
		n = 0;
		while (op_ready !== 1'b1) begin
			n++;
			if (n > 10) begin
				chk("ready wait", 32'h0, 32'h1);
				stop_test();
			end
			@(negedge mclk);
		end
		@(negedge mclk);
		// selects move after the take; the decode must not follow them
		{bank_select_high, bank_select_low, pointer_select_bit} = ~sel;
		if (nag >= 0)
			pc = 7'(nag);
		else
			fetch = 1'b0;
		chk("opcode", dec.opcode, e[15:8]);
		chk("bytes", dec.len, e[7:4]);
		chk("cycles", dec.cyc, e[3:0]);
		chk("ready low", op_ready, 32'h0);
		chk("done low", done, 32'h0);
		n = 0;
		while (busy === 1'b1 && n < 9) begin
			n++;
			@(negedge mclk);
		end
		chk("busy length", 32'(n), e[3:0]);
		// a stuck busy has already counted a mismatch; stop here
		if (n >= 9)
			stop_test();
		chk("done", done, 32'h1);
		chk("ready back", op_ready, 32'h1);
		chk("opcode held", dec.opcode, e[15:8]);
	endtask

	task automatic t_reset();
		chk("reset ready", op_ready, 32'h1);
		chk("reset busy", busy, 32'h0);
		chk("reset done", done, 32'h0);
		chk("reset dec", dec, 32'h0);
		$display("test reset done");
	endtask

	// every bank with a register form, then an indirect form
	task automatic t_regs();
		for (int b = 0; b < 4; b++) begin
			run_op(0, {2'(b), 1'b0}, -1);
			chk("reg addr", dec.reg_addr, {2'(b), 3'h3});
			chk("reg form", dec.form, scd_pkg::FRM_REG);
			chk("reg class", dec.cls, scd_pkg::CLS_ARITH);
			chk("no pointer", dec.active_data_pointer_use, 32'h0);
		end
		run_op(1, 3'h6, -1);
		chk("ind addr", dec.reg_addr, 32'h19);
		chk("ind form", dec.form, scd_pkg::FRM_IND);
		$display("test regs done");
	endtask

	task automatic t_active_data_pointer();
		for (int p = 0; p < 2; p++) begin
			run_op(2, 3'(p), -1);
			chk("ptr use", dec.active_data_pointer_use, 32'h1);
			chk("ptr sel", dec.active_data_pointer_sel, 32'(p));
		end
		run_op(3, 3'h0, -1);
		chk("reserved", dec.cls, scd_pkg::CLS_RSVD);
		$display("test active_data_pointer done");
	endtask

	// reset in the middle of a long call drops it at once
	task automatic t_midreset();
		pc = 7'h04;
		fetch = 1'b1;
		@(negedge mclk);
		fetch = 1'b0;
		chk("mid busy", busy, 32'h1);
		chk("call class", dec.cls, scd_pkg::CLS_BRANCH);
		rst_b = 1'b0;
		@(negedge mclk);
		rst_b = 1'b1;
		chk("mid reset busy", busy, 32'h0);
		chk("mid reset ready", op_ready, 32'h1);
		chk("mid reset dec", dec, 32'h0);
		@(negedge mclk);
		chk("mid reset done", done, 32'h0);
		chk("mid reset idle", op_ready, 32'h1);
		$display("test midreset done");
	endtask

	// table entries 3 to 67 back to back, next opcode offered while busy
	task automatic t_table();
		for (int i = 3; i < 68; i++)
			run_op(i, 3'(i), i < 67 ? i + 1 : -1);
		$display("test table done");
	endtask

	// load memory, reset for 4 cycles, then run the scenarios
	initial begin
		for (int i = 0; i < 68; i++)
			u_scd_pmem.mem[i] = tab[i][15:8];
		repeat (4) @(negedge mclk);
		rst_b = 1'b1;
		@(negedge mclk);
		t_reset();
		t_regs();
		t_active_data_pointer();
		t_midreset();
		t_table();
		stop_test();
	end
endmodule // single_cycle_cpu_opcode_timing_bench
